// >>> src/flash_host_regs.vh
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

// Register byte offsets
`define REG_CTRL        5'h00
`define REG_ADDR        5'h04
`define REG_WDATA       5'h08
`define REG_STATUS      5'h0C
`define REG_RDATA       5'h10

// Control register fields
`define CTRL_OP_HI      2
`define CTRL_OP_LO      0
`define CTRL_BYTE_BIT   3
`define CTRL_GO_BIT     8

// Operation codes
`define OP_READ         3'h0
`define OP_WRITE        3'h1
`define OP_PROTECT      3'h2
`define OP_UNPROTECT    3'h3
`define OP_RESET        3'h4

// Status register fields
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define STAT_RDY_BIT    2

// Protect and unprotect address bits
`define PROT_SEL_BIT    6
`define PROT_A1_BIT     1
`define PROT_A0_BIT     0

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Timing in ns, then synchroniser depth in stages
`define CLK_NS          20
`define ACC_NS          120
`define WP_NS           60
`define RP_NS           500
`define SETUP_NS        20
`define SYNC_STAGES     2

`endif

// >>> src/flash_host.v
// Summary of operation
// - Read: chip enable and output enable low, write enable high, sample data.
// - Write: chip enable and write enable low, output enable high, drive data.
// - Address is twenty bits in word mode, twenty-one with the top pin in byte mode.
// - Bypass programs in two writes, otherwise four; each write is one cycle here.
// - Protect: chip enable low, write low, output high, reset at high voltage, A6 low.
// - Unprotect: same levels as protect, but A6 driven high.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.vh"

module flash_host #(
  parameter RP_CYC_P = ((`RP_NS + `CLK_NS - 1) / `CLK_NS)
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [19:0] flash_addr,
  output reg  [15:0] flash_dq_o,
  input  wire [15:0] flash_dq_i,
  output reg         flash_dq_oe_lo,
  output reg         flash_dq_oe_mid,
  output reg         flash_dq_oe_top,
  output reg         chip_enable_n,
  output reg         output_enable_n,
  output reg         write_enable_n,
  output reg         hw_reset_n,
  output reg         high_voltage_en,
  output reg         width_select_n,
  input  wire        ready_busy_n
);

  localparam [7:0] ACC_CYC   = ((`ACC_NS + `CLK_NS - 1) / `CLK_NS) + `SYNC_STAGES;
  localparam [7:0] WP_CYC    = ((`WP_NS + `CLK_NS - 1) / `CLK_NS);
  localparam [7:0] SETUP_CYC = ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS);
  localparam [7:0] RP_CYC    = RP_CYC_P[7:0];

  localparam [3:0] S_IDLE   = 4'h1;
  localparam [3:0] S_SETUP  = 4'h2;
  localparam [3:0] S_STROBE = 4'h4;
  localparam [3:0] S_HOLD   = 4'h8;

  reg  [3:0]  state_q;
  reg  [7:0]  cnt_q;
  reg  [2:0]  op_q;
  reg         byte_q;
  reg  [20:0] addr_q;
  reg  [15:0] wdata_q;
  reg  [15:0] rdata_q;
  reg         done_q;
  reg  [4:0]  aw_addr_q;
  reg         aw_have_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_have_q;
  reg  [15:0] dq_meta_q;
  reg  [15:0] dq_sync_q;
  reg         rb_meta_q;
  reg         rb_sync_q;
  reg         go_q;
  wire        go_req;
  wire        busy;
  wire [31:0] addr_mrg;
  wire [31:0] wdata_mrg;

  // Byte-lane merge of a bus write into a stored word
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // Status word assembled from block state
  function [31:0] status_word;
    input b;
    input d;
    input r;
    begin
      status_word = 32'h0000_0000;
      status_word[`STAT_BUSY_BIT] = b;
      status_word[`STAT_DONE_BIT] = d;
      status_word[`STAT_RDY_BIT]  = r;
    end
  endfunction

  // Byte-lane merges of a pending bus write into the address and data words
  assign addr_mrg  = merge({11'h000, addr_q}, w_data_q, w_strb_q);
  assign wdata_mrg = merge({16'h0000, wdata_q}, w_data_q, w_strb_q);

  assign busy   = ~state_q[0];
  assign go_req = aw_have_q && w_have_q && !s_axi_bvalid && (aw_addr_q == `REG_CTRL) &&
                  w_strb_q[1] && w_data_q[`CTRL_GO_BIT] && !busy;

  // Two-flop synchronisers for device inputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      dq_meta_q <= 16'h0000;
      dq_sync_q <= 16'h0000;
      rb_meta_q <= 1'b1;
      rb_sync_q <= 1'b1;
    end else begin
      dq_meta_q <= flash_dq_i;
      dq_sync_q <= dq_meta_q;
      rb_meta_q <= ready_busy_n;
      rb_sync_q <= rb_meta_q;
    end
  end

  // AXI write channels, address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 5'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      addr_q        <= 21'h000000;
      wdata_q       <= 16'h0000;
      op_q          <= `OP_READ;
      byte_q        <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr_q)
          `REG_CTRL: begin
            if (!busy && w_strb_q[0]) begin
              op_q   <= w_data_q[`CTRL_OP_HI:`CTRL_OP_LO];
              byte_q <= w_data_q[`CTRL_BYTE_BIT];
            end
          end
          `REG_ADDR: begin
            if (!busy) begin
              addr_q <= addr_mrg[20:0];
            end
          end
          `REG_WDATA: begin
            if (!busy) begin
              wdata_q <= wdata_mrg[15:0];
            end
          end
          `REG_STATUS, `REG_RDATA: begin
            s_axi_bresp <= `RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel, answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `REG_CTRL:   s_axi_rdata <= {28'h0000000, byte_q, op_q};
          `REG_ADDR:   s_axi_rdata <= {11'h000, addr_q};
          `REG_WDATA:  s_axi_rdata <= {16'h0000, wdata_q};
          `REG_STATUS: s_axi_rdata <= status_word(busy, done_q, rb_sync_q);
          `REG_RDATA:  s_axi_rdata <= {16'h0000, rdata_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Flash bus cycle sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q         <= S_IDLE;
      go_q            <= 1'b0;
      cnt_q           <= 8'h00;
      done_q          <= 1'b0;
      rdata_q         <= 16'h0000;
      flash_addr      <= 20'h00000;
      flash_dq_o      <= 16'h0000;
      flash_dq_oe_lo  <= 1'b0;
      flash_dq_oe_mid <= 1'b0;
      flash_dq_oe_top <= 1'b0;
      chip_enable_n   <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n  <= 1'b1;
      hw_reset_n      <= 1'b1;
      high_voltage_en <= 1'b0;
      width_select_n  <= 1'b1;
    end else begin
      // Go acts a cycle late so the sequencer sees the op and width written with it
      go_q <= go_req;
      case (state_q)
        S_IDLE: begin
          // Standby between cycles: deselected, strobes high, bus floated
          chip_enable_n   <= 1'b1;
          output_enable_n <= 1'b1;
          write_enable_n  <= 1'b1;
          flash_dq_oe_lo  <= 1'b0;
          flash_dq_oe_mid <= 1'b0;
          flash_dq_oe_top <= 1'b0;
          high_voltage_en <= 1'b0;
          if (go_q) begin
            done_q         <= 1'b0;
            cnt_q          <= SETUP_CYC;
            state_q        <= S_SETUP;
            width_select_n <= !byte_q;
            if (byte_q) begin
              flash_addr <= addr_q[20:1];
            end else begin
              flash_addr <= addr_q[19:0];
            end
            case (op_q)
              `OP_READ: begin
                chip_enable_n   <= 1'b0;
                flash_dq_oe_top <= byte_q;
                flash_dq_o      <= {addr_q[0], 15'h0000};
              end
              `OP_WRITE: begin
                chip_enable_n   <= 1'b0;
                flash_dq_oe_lo  <= 1'b1;
                flash_dq_oe_mid <= !byte_q;
                flash_dq_oe_top <= 1'b1;
                flash_dq_o      <= byte_q ? {addr_q[0], 7'h00, wdata_q[7:0]} : wdata_q;
              end
              `OP_PROTECT, `OP_UNPROTECT: begin
                chip_enable_n   <= 1'b0;
                high_voltage_en <= 1'b1;
                flash_dq_oe_lo  <= 1'b1;
                flash_dq_o      <= wdata_q;
                flash_addr      <= addr_q[19:0];
                flash_addr[`PROT_SEL_BIT] <= (op_q == `OP_UNPROTECT);
                flash_addr[`PROT_A1_BIT]  <= 1'b1;
                flash_addr[`PROT_A0_BIT]  <= 1'b0;
                flash_dq_oe_top <= byte_q;
                if (byte_q) begin
                  flash_dq_o[15] <= addr_q[0];
                end
              end
              default: begin
                hw_reset_n <= 1'b0;
                cnt_q      <= RP_CYC;
                state_q    <= S_STROBE;
              end
            endcase
          end
        end
        S_SETUP: begin
          // Address and data settle before the strobe falls
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            state_q <= S_STROBE;
            if (op_q == `OP_READ) begin
              output_enable_n <= 1'b0;
              cnt_q           <= ACC_CYC;
            end else begin
              write_enable_n <= 1'b0;
              cnt_q          <= WP_CYC;
            end
          end
        end
        S_STROBE: begin
          // Strobe held for access, write pulse or reset time
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            if (op_q == `OP_READ) begin
              rdata_q <= byte_q ? {8'h00, dq_sync_q[7:0]} : dq_sync_q;
            end
            output_enable_n <= 1'b1;
            write_enable_n  <= 1'b1;
            hw_reset_n      <= 1'b1;
            cnt_q           <= SETUP_CYC;
            state_q         <= S_HOLD;
          end
        end
        S_HOLD: begin
          // Data and address held past the rising strobe
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            chip_enable_n   <= 1'b1;
            high_voltage_en <= 1'b0;
            flash_dq_oe_lo  <= 1'b0;
            flash_dq_oe_mid <= 1'b0;
            flash_dq_oe_top <= byte_q;
            done_q          <= 1'b1;
            state_q         <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // flash_host

`default_nettype wire

// >>> verification/flash_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [19:0] flash_addr,
  input wire logic        flash_dq_oe_lo,
  input wire logic        flash_dq_oe_mid,
  input wire logic        flash_dq_oe_top,
  input wire logic        chip_enable_n,
  input wire logic        output_enable_n,
  input wire logic        write_enable_n,
  input wire logic        hw_reset_n,
  input wire logic        high_voltage_en,
  input wire logic        width_select_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_strobe_excl: assert property (output_enable_n || write_enable_n)
    else $error("Both strobes low");
  a_read_gate: assert property (!output_enable_n |-> !chip_enable_n && write_enable_n
    && !flash_dq_oe_lo && !flash_dq_oe_mid) else $error("Read strobe badly framed");
  a_write_drive: assert property (!write_enable_n |-> !chip_enable_n && output_enable_n
    && flash_dq_oe_lo) else $error("Write strobe badly framed");
  a_word_lanes: assert property (!write_enable_n && width_select_n && !high_voltage_en
    |-> flash_dq_oe_mid && flash_dq_oe_top) else $error("Word write lanes off");
  a_byte_float: assert property (!width_select_n |-> !flash_dq_oe_mid)
    else $error("Middle lanes driven in byte mode");
  a_we_width: assert property ($fell(write_enable_n) |-> !write_enable_n[*3] ##1 write_enable_n)
    else $error("Write pulse not three cycles");
  a_oe_width: assert property ($fell(output_enable_n) |-> !output_enable_n[*8] ##1 output_enable_n)
    else $error("Read pulse not eight cycles");
  a_ce_release: assert property ($rose(output_enable_n) |-> !chip_enable_n ##1 chip_enable_n)
    else $error("Chip enable not held through hold cycle");
  a_prot_levels: assert property (high_voltage_en |-> !chip_enable_n && output_enable_n
    && hw_reset_n && (write_enable_n || flash_addr[1] && !flash_addr[0]))
    else $error("Protect levels wrong");
  a_reset_quiet: assert property (!hw_reset_n |-> chip_enable_n && output_enable_n
    && write_enable_n && !high_voltage_en) else $error("Strobes active in reset");
endmodule // flash_host_checker

bind flash_host flash_host_checker chk_u (.*);
`default_nettype wire

// >>> verification/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] ID_P = 8'h5A // Arbitrary identification value
) (
  input  wire logic        aclk,
  input  wire logic [19:0] flash_addr,
  input  wire logic [15:0] flash_dq_o,
  input  wire logic        flash_dq_oe_lo,
  input  wire logic        flash_dq_oe_mid,
  input  wire logic        flash_dq_oe_top,
  input  wire logic        chip_enable_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic        hw_reset_n,
  input  wire logic        high_voltage_en,
  input  wire logic        width_select_n,
  output var  logic [15:0] flash_dq_i = 16'h0000,
  output wire logic        ready_busy_n
);
  logic [15:0] mem [int];
  logic [15:0] cmd_d, arr, rd;
  logic [19:0] cmd_a;
  logic [1:0]  step = 2'h0;
  logic        prog = 1'b0, byp = 1'b0, asel = 1'b0, ers = 1'b0, we_q = 1'b1, drv, hd;

  // Operations finish at once, so never busy
  assign ready_busy_n = 1'b1;

  // Mode state moves as each write cycle without high voltage ends; bus resolved every cycle
  always @(posedge aclk) begin
    if (!hw_reset_n) begin
      {step, prog, byp, asel, ers} = 6'h00;
    end else if (write_enable_n && !we_q && !chip_enable_n && !high_voltage_en) begin
      cmd_a = flash_addr;
      cmd_d = flash_dq_o;
      arr = mem.exists(cmd_a) ? mem[cmd_a] : 16'hFFFF;
      if (prog) begin
        mem[cmd_a] = width_select_n ? cmd_d :
          (cmd_d[15] ? {cmd_d[7:0], arr[7:0]} : {arr[15:8], cmd_d[7:0]});
        {step, prog} = 3'h0;
      end else if (cmd_d[7:0] == 8'hF0) {step, byp, asel, ers} = 5'h00;
      else if (byp && cmd_d[7:0] == 8'hA0) prog = 1'b1;
      else if (step == 2'h0 && cmd_a[10:0] == 11'h555 && cmd_d[7:0] == 8'hAA) step = 2'h1;
      else if (step == 2'h1 && cmd_a[10:0] == 11'h2AA && cmd_d[7:0] == 8'h55) step = 2'h2;
      else begin
        // Erase of the whole array or of the sector named by the upper address bits
        if (step == 2'h2 && ers && cmd_d[7:0] == 8'h10) mem.delete();
        if (step == 2'h2 && ers && cmd_d[7:0] == 8'h30)
          for (int k = 0; k < 32768; k++)
            if (mem.exists({cmd_a[19:15], k[14:0]})) mem.delete({cmd_a[19:15], k[14:0]});
        ers = step == 2'h2 && cmd_d[7:0] == 8'h80;
        prog = step == 2'h2 && cmd_d[7:0] == 8'hA0;
        asel = asel || (step == 2'h2 && cmd_d[7:0] == 8'h90);
        byp = byp || (step == 2'h2 && cmd_d[7:0] == 8'h20);
        step = 2'h0;
      end
    end
    we_q = write_enable_n;
    arr = mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF;
    rd = asel ? {8'h00, ID_P} : arr;
    if (!width_select_n) rd = {8'h00, flash_dq_o[15] ? rd[15:8] : rd[7:0]};
    drv = !chip_enable_n && !output_enable_n && write_enable_n && hw_reset_n;
    for (int i = 0; i < 16; i++) begin
      hd = i < 8 ? flash_dq_oe_lo : (i < 15 ? flash_dq_oe_mid : flash_dq_oe_top);
      if (hd) flash_dq_i[i] <= flash_dq_o[i];
      else if (drv && (i < 8 || width_select_n)) flash_dq_i[i] <= rd[i];
      else flash_dq_i[i] <= ~flash_dq_i[i];
    end
  end
endmodule // flash_dev_model
`default_nettype wire

// >>> verification/flash_bus_operation_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.vh"
module flash_bus_operation_decoder_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, flash_dq_oe_lo, flash_dq_oe_mid, flash_dq_oe_top, chip_enable_n;
  logic        output_enable_n, write_enable_n, hw_reset_n, high_voltage_en, width_select_n;
  logic        ready_busy_n;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_o, flash_dq_i;
  int          n_fail = 0, check_count = 0;
  typedef struct packed {
    logic [2:0]  op;
    logic        bm;
    logic [20:0] a;
    logic [15:0] v;
  } row_t;
  localparam logic [2:0] RD = `OP_READ;
  localparam logic [2:0] WR = `OP_WRITE;
  // Operation, byte mode, address, then write data or expected read data
  row_t rows [38] = '{
    '{RD, 1'b0, 21'h00123, 16'hFFFF}, '{WR, 1'b0, 21'h00555, 16'h00AA},
    '{WR, 1'b0, 21'h002AA, 16'h0055}, '{WR, 1'b0, 21'h00555, 16'h00A0},
    '{WR, 1'b0, 21'h00123, 16'hBEEF}, '{RD, 1'b0, 21'h00123, 16'hBEEF},
    '{RD, 1'b0, 21'h00555, 16'hFFFF}, '{WR, 1'b0, 21'h00555, 16'h00AA},
    '{WR, 1'b0, 21'h002AA, 16'h0055}, '{WR, 1'b0, 21'h00555, 16'h0020},
    '{WR, 1'b0, 21'h00000, 16'h00A0}, '{WR, 1'b0, 21'h00200, 16'h1234},
    '{RD, 1'b0, 21'h00200, 16'h1234}, '{WR, 1'b0, 21'h00000, 16'h00F0},
    '{RD, 1'b1, 21'h00247, 16'h00BE}, '{RD, 1'b1, 21'h00246, 16'h00EF},
    '{WR, 1'b0, 21'h00555, 16'h00AA}, '{WR, 1'b0, 21'h002AA, 16'h0055},
    '{WR, 1'b0, 21'h00555, 16'h0090}, '{RD, 1'b0, 21'h00000, 16'h005A},
    '{`OP_RESET, 1'b0, 21'h00000, 16'h0000}, '{RD, 1'b0, 21'h00123, 16'hBEEF},
    '{`OP_PROTECT, 1'b0, 21'h0F8000, 16'h0000}, '{RD, 1'b0, 21'h00123, 16'hBEEF},
    '{`OP_UNPROTECT, 1'b0, 21'h0F8000, 16'h0000}, '{RD, 1'b0, 21'h00123, 16'hBEEF},
    '{WR, 1'b0, 21'h00555, 16'h00AA}, '{WR, 1'b0, 21'h002AA, 16'h0055},
    '{WR, 1'b0, 21'h00555, 16'h00A0}, '{WR, 1'b0, 21'h08000, 16'hCAFE},
    '{WR, 1'b0, 21'h00555, 16'h00AA}, '{WR, 1'b0, 21'h002AA, 16'h0055},
    '{WR, 1'b0, 21'h00555, 16'h0080}, '{WR, 1'b0, 21'h00555, 16'h00AA},
    '{WR, 1'b0, 21'h002AA, 16'h0055}, '{WR, 1'b0, 21'h08000, 16'h0030},
    '{RD, 1'b0, 21'h08000, 16'hFFFF}, '{RD, 1'b0, 21'h00123, 16'hBEEF}};

  flash_host #(.RP_CYC_P(2)) dut_u (.*);
  flash_dev_model model_u (.*);

  // Free-running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Register write: address and data offered together, each released when taken
  task automatic axw(input logic [4:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Register read: address held until taken, data taken with rvalid
  task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One flash operation: load address and data, start, wait for done, fetch read data
  task automatic run(input logic [2:0] op, input logic bm, input logic [20:0] a,
                     input logic [15:0] d);
    axw(`REG_ADDR, {11'h000, a}, r);
    axw(`REG_WDATA, {16'h0000, d}, r);
    axw(`REG_CTRL, {23'h000000, 1'b1, 4'h0, bm, op}, r);
    do axr(`REG_STATUS, rd_v, r);
    while (rd_v[`STAT_DONE_BIT] !== 1'b1);
    axr(`REG_RDATA, rd_v, r);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    tally_and_finish;
  end

  // Reset, table of operations, then unmapped access and reset in mid-operation
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {42'h0, 4'hF};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].bm, rows[i].a, rows[i].v);
      if (rows[i].op == RD) chk(rd_v, {16'h0000, rows[i].v});
      $display("row %0d done", i);
    end
    axw(5'h14, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    axr(5'h14, rd_v, r);
    chk({r, rd_v[29:0]}, {`RESP_SLVERR, 30'h0});
    $display("unmapped access test done");
    axw(`REG_ADDR, 32'h0000_0123, r);
    axw(`REG_CTRL, 32'h0000_0100, r);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    chk({27'h0, chip_enable_n, output_enable_n, write_enable_n, hw_reset_n, width_select_n},
        32'h0000_001F);
    aresetn <= 1'b1;
    axr(`REG_STATUS, rd_v, r);
    chk(rd_v, 32'h0000_0004);
    run(RD, 1'b0, 21'h00123, 16'h0000);
    chk(rd_v, 32'h0000_BEEF);
    $display("mid-operation reset test done");
    tally_and_finish;
  end
endmodule // flash_bus_operation_decoder_tb
`default_nettype wire
